// File: hw/temp_i2c_port.sv
/*
 * Battery-temperature event flag and a single-byte two-wire target port
 * with a six-write unlock that takes the port off the bus.
 * Assumes SCL comes from the host and clocks the link logic; resetn is
 * synchronous to ref_clk and is also seen by the link logic through SCL.
 */
`timescale 1ns/1ns
module temp_i2c_port (
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	input  wire logic  temp_in_range,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	output logic       sda_out,
	output logic       sda_oe,
	output logic       temp_event_flag,
	output logic       temp_in_range_level,
	output logic       temp_exit_irq_enable,
	output logic       temp_return_irq_enable,
	output logic       temp_report_enable,
	output logic       port_disabled
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain (SCL)

	logic                       link_rstn_s1_reg;
	logic                       link_rstn_reg;
	logic                       start_tgl_reg;
	logic                       start_seen_reg;
	temp_i2c_pkg::link_state_e  state_reg;
	logic [2:0]                 bit_cnt_reg;
	logic [7:0]                 shift_reg;
	logic [7:0]                 reg_addr_reg;
	temp_i2c_pkg::reg_write_s   wr_word_reg;
	logic                       wr_tgl_reg;
	logic                       clr_tgl_reg;
	logic                       drive_low_reg;
	logic [4:0]                 rd_s1_reg;
	logic [4:0]                 rd_s2_reg;
	logic                       dis_s1_reg;
	logic                       dis_s2_reg;
	logic [7:0]                 shift_next;
	logic                       start_now;
	logic [7:0]                 read_byte;

	assign shift_next = {shift_reg[6:0], sda_in};
	assign start_now  = start_tgl_reg != start_seen_reg;
	assign read_byte  = (reg_addr_reg == temp_i2c_pkg::TEMP_REG_ADDR) ? {3'h0, rd_s2_reg} : 8'h00;

	// START marker: SDA falling while SCL high
	always_ff @(negedge sda_in) begin
		if (!resetn) begin
			start_tgl_reg <= 1'b0;
		end else if (scl_in) begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	always_ff @(posedge scl_in) begin
		link_rstn_s1_reg <= resetn;
		link_rstn_reg    <= link_rstn_s1_reg;
	end

	// Status bits and disable level into the link domain
	always_ff @(posedge scl_in) begin
		rd_s1_reg  <= {temp_in_range_level, temp_event_flag, temp_report_enable,
			temp_return_irq_enable, temp_exit_irq_enable};
		rd_s2_reg  <= rd_s1_reg;
		dis_s1_reg <= port_disabled;
		dis_s2_reg <= dis_s1_reg;
	end

	always_ff @(posedge scl_in) begin
		if (!link_rstn_reg) begin
			state_reg      <= temp_i2c_pkg::ST_IDLE;
			start_seen_reg <= start_tgl_reg;
			bit_cnt_reg    <= 3'h0;
			shift_reg      <= 8'h00;
			reg_addr_reg   <= 8'h00;
			wr_word_reg    <= '0;
			wr_tgl_reg     <= 1'b0;
			clr_tgl_reg    <= 1'b0;
		end else if (dis_s2_reg) begin
			state_reg      <= temp_i2c_pkg::ST_IDLE;
			start_seen_reg <= start_tgl_reg;
		end else if (start_now) begin
			start_seen_reg <= start_tgl_reg;
			state_reg      <= temp_i2c_pkg::ST_ADDR;
			bit_cnt_reg    <= 3'h1;
			shift_reg      <= shift_next;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= shift_next;
			case (state_reg)
				temp_i2c_pkg::ST_ADDR: begin
					if (bit_cnt_reg == 3'h7) begin
						state_reg <= (shift_reg[6:0] == temp_i2c_pkg::DEV_ADDR) ?
							temp_i2c_pkg::ST_ACK_ADDR : temp_i2c_pkg::ST_IGNORE;
					end
				end
				temp_i2c_pkg::ST_ACK_ADDR: begin
					bit_cnt_reg <= 3'h0;
					if (shift_reg[0]) begin
						state_reg <= temp_i2c_pkg::ST_RDATA;
						shift_reg <= read_byte;
						if (read_byte[temp_i2c_pkg::FLAG_BIT]) begin
							clr_tgl_reg <= ~clr_tgl_reg;
						end
					end else begin
						state_reg <= temp_i2c_pkg::ST_REG;
					end
				end
				temp_i2c_pkg::ST_REG: begin
					if (bit_cnt_reg == 3'h7) begin
						state_reg    <= temp_i2c_pkg::ST_ACK_REG;
						reg_addr_reg <= shift_next;
					end
				end
				temp_i2c_pkg::ST_ACK_REG: begin
					bit_cnt_reg <= 3'h0;
					state_reg   <= temp_i2c_pkg::ST_WDATA;
				end
				temp_i2c_pkg::ST_WDATA: begin
					if (bit_cnt_reg == 3'h7) begin
						state_reg   <= temp_i2c_pkg::ST_ACK_DATA;
						wr_word_reg <= '{addr: reg_addr_reg, data: shift_next};
						wr_tgl_reg  <= ~wr_tgl_reg;
					end
				end
				temp_i2c_pkg::ST_ACK_DATA: begin
					state_reg <= temp_i2c_pkg::ST_IGNORE;
				end
				temp_i2c_pkg::ST_RDATA: begin
					if (bit_cnt_reg == 3'h7) begin
						state_reg <= temp_i2c_pkg::ST_RACK;
					end
				end
				temp_i2c_pkg::ST_RACK: begin
					state_reg <= temp_i2c_pkg::ST_IGNORE;
				end
				default: begin
					state_reg <= state_reg;
				end
			endcase
		end
	end

	// SDA is changed only while SCL is low
	always_ff @(negedge scl_in) begin
		if (!link_rstn_reg || dis_s2_reg) begin
			drive_low_reg <= 1'b0;
		end else begin
			case (state_reg)
				temp_i2c_pkg::ST_ACK_ADDR,
				temp_i2c_pkg::ST_ACK_REG,
				temp_i2c_pkg::ST_ACK_DATA: drive_low_reg <= 1'b1;
				temp_i2c_pkg::ST_RDATA:    drive_low_reg <= ~shift_reg[7];
				default:                   drive_low_reg <= 1'b0;
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = drive_low_reg;

	////////////////////////////////////////////////////////////////////////////
	// Core domain (ref_clk)

	logic                    range_s1_reg;
	logic                    range_reg;
	logic [2:0]              wr_sync_reg;
	logic [2:0]              clr_sync_reg;
	temp_i2c_pkg::temp_cfg_s cfg_reg;
	logic                    flag_reg;
	logic [2:0]              seq_cnt_reg;
	logic                    disabled_reg;
	logic                    wr_ev;
	logic                    clr_ev;
	logic                    exit_ev;
	logic                    return_ev;
	logic                    seq_hit;
	logic                    seq_first;

	assign wr_ev     = wr_sync_reg[1] ^ wr_sync_reg[2];
	assign clr_ev    = clr_sync_reg[1] ^ clr_sync_reg[2];
	assign exit_ev   = temp_in_range_level & ~range_reg;
	assign return_ev = ~temp_in_range_level & range_reg;

	always_ff @(posedge ref_clk) begin
		range_s1_reg <= temp_in_range;
		range_reg    <= range_s1_reg;
		wr_sync_reg  <= {wr_sync_reg[1:0], wr_tgl_reg};
		clr_sync_reg <= {clr_sync_reg[1:0], clr_tgl_reg};
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			temp_in_range_level <= 1'b0;
		end else begin
			temp_in_range_level <= range_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfg_reg <= temp_i2c_pkg::TEMP_CFG_RESET;
		end else if (wr_ev && wr_word_reg.addr == temp_i2c_pkg::TEMP_REG_ADDR) begin
			cfg_reg <= '{report_en: wr_word_reg.data[temp_i2c_pkg::REPORT_EN_BIT],
				return_en: wr_word_reg.data[temp_i2c_pkg::RETURN_EN_BIT],
				exit_en:   wr_word_reg.data[temp_i2c_pkg::EXIT_EN_BIT]};
		end
	end

	// Set wins over a read-clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			flag_reg <= 1'b0;
		end else if (cfg_reg.report_en && ((cfg_reg.exit_en && exit_ev) ||
			(cfg_reg.return_en && return_ev))) begin
			flag_reg <= 1'b1;
		end else if (clr_ev) begin
			flag_reg <= 1'b0;
		end
	end

	always_comb begin
		seq_first = wr_word_reg.addr == temp_i2c_pkg::SEQ_ADDR_A &&
			wr_word_reg.data == temp_i2c_pkg::SEQ_DATA_A1;
		case (seq_cnt_reg)
			3'h0: seq_hit = seq_first;
			3'h3: seq_hit = wr_word_reg.addr == temp_i2c_pkg::SEQ_ADDR_A &&
				wr_word_reg.data == temp_i2c_pkg::SEQ_DATA_A2;
			3'h1, 3'h4: seq_hit = wr_word_reg.addr == temp_i2c_pkg::SEQ_ADDR_B &&
				wr_word_reg.data == temp_i2c_pkg::SEQ_DATA_B;
			3'h2, 3'h5: seq_hit = wr_word_reg.addr == temp_i2c_pkg::SEQ_ADDR_C &&
				wr_word_reg.data == temp_i2c_pkg::SEQ_DATA_C;
			default: seq_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			seq_cnt_reg  <= 3'h0;
			disabled_reg <= 1'b0;
		end else if (wr_ev && !disabled_reg) begin
			if (seq_hit) begin
				seq_cnt_reg  <= seq_cnt_reg + 3'h1;
				disabled_reg <= (seq_cnt_reg + 3'h1) == temp_i2c_pkg::SEQ_LEN;
			end else begin
				seq_cnt_reg <= seq_first ? 3'h1 : 3'h0;
			end
		end
	end

	assign temp_event_flag        = flag_reg;
	assign temp_exit_irq_enable   = cfg_reg.exit_en;
	assign temp_return_irq_enable = cfg_reg.return_en;
	assign temp_report_enable     = cfg_reg.report_en;
	assign port_disabled          = disabled_reg;

endmodule : temp_i2c_port

// File: hw/temp_i2c_pkg.sv
/*
 * Constants and carriers for the battery-temperature event logic and its
 * single-byte two-wire target port.
 * Assumes one system clock (ref_clk) and a host controller that drives SCL.
 */
package temp_i2c_pkg;

	// Own target address (arbitrary value)
	localparam logic [6:0] DEV_ADDR       = 7'h5B;
	localparam logic [7:0] TEMP_REG_ADDR  = 8'h79;

	// Temperature register field positions
	localparam int         EXIT_EN_BIT    = 0;
	localparam int         RETURN_EN_BIT  = 1;
	localparam int         REPORT_EN_BIT  = 2;
	localparam int         FLAG_BIT       = 3;
	localparam int         LEVEL_BIT      = 4;
	localparam logic [2:0] TEMP_CFG_RESET = 3'h0;

	// Disable sequence
	localparam logic [2:0] SEQ_LEN        = 3'h6;
	localparam logic [7:0] SEQ_ADDR_A     = 8'h0B;
	localparam logic [7:0] SEQ_ADDR_B     = 8'h02;
	localparam logic [7:0] SEQ_ADDR_C     = 8'h03;
	localparam logic [7:0] SEQ_DATA_A1    = 8'hEE;
	localparam logic [7:0] SEQ_DATA_A2    = 8'hEF;
	localparam logic [7:0] SEQ_DATA_B     = 8'h07;
	localparam logic [7:0] SEQ_DATA_C     = 8'h01;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed {
		logic report_en;
		logic return_en;
		logic exit_en;
	} temp_cfg_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
		ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RACK, ST_IGNORE
	} link_state_e;

endpackage : temp_i2c_pkg

// File: tb/temp_i2c_port_props.sv
/* Checker on the temp_i2c_port pins.
 * Assumes it is bound to every temp_i2c_port instance. */
`timescale 1ns/1ns
module temp_i2c_port_props (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic temp_in_range,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic temp_event_flag,
	input wire logic temp_in_range_level,
	input wire logic temp_exit_irq_enable,
	input wire logic temp_return_irq_enable,
	input wire logic temp_report_enable,
	input wire logic port_disabled
);
	logic [3:0] quiet_cnt;
	logic       scl_q;
	logic [3:0] oe_rise_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Ref cycles since the last SCL edge
	always_ff @(posedge ref_clk) begin
		scl_q <= scl_in;
		if (!resetn || scl_q != scl_in)
			quiet_cnt <= 4'h0;
		else if (quiet_cnt != 4'hF)
			quiet_cnt <= quiet_cnt + 4'h1;
	end
	// SCL rises seen while the port holds SDA low
	always_ff @(posedge ref_clk) begin
		if (!resetn || !sda_oe) begin
			oe_rise_cnt <= 4'h0;
		end else if (!scl_q && scl_in && oe_rise_cnt != 4'hF) begin
			oe_rise_cnt <= oe_rise_cnt + 4'h1;
		end
	end
	property p_level; $stable(temp_in_range) [*6] |-> temp_in_range_level == temp_in_range; endproperty
	a_level: assert property (p_level) else $error("level differs from pin");
	property p_exit; $fell(temp_in_range_level) && temp_exit_irq_enable && temp_report_enable
		|=> temp_event_flag; endproperty
	a_exit: assert property (p_exit) else $error("no flag on exit");
	property p_ret; $rose(temp_in_range_level) && temp_return_irq_enable && temp_report_enable
		|=> temp_event_flag; endproperty
	a_ret: assert property (p_ret) else $error("no flag on return");
	// Flag and level update on the same edge
	property p_cause; $rose(temp_event_flag) |-> $past(temp_report_enable)
		&& temp_in_range_level != $past(temp_in_range_level); endproperty
	a_cause: assert property (p_cause) else $error("flag set without event");
	property p_clear; $fell(temp_event_flag) |-> quiet_cnt < 4'h8; endproperty
	a_clear: assert property (p_clear) else $error("flag cleared without read");
	// At most an acknowledge plus one byte under a single continuous pull
	property p_low; sda_oe |-> !sda_out && oe_rise_cnt <= 4'h9; endproperty
	a_low: assert property (p_low) else $error("data held low too long");
	property p_oe; $changed(sda_oe) |-> !scl_in; endproperty
	a_oe: assert property (p_oe) else $error("data enable moved with clock high");
	property p_off; port_disabled && $past(port_disabled, 8) |-> !sda_oe; endproperty
	a_off: assert property (p_off) else $error("disabled port drives data");
endmodule : temp_i2c_port_props
bind temp_i2c_port temp_i2c_port_props temp_i2c_port_props_inst (.ref_clk, .resetn,
	.temp_in_range, .scl_in, .sda_in, .sda_out, .sda_oe, .temp_event_flag, .temp_in_range_level,
	.temp_exit_irq_enable, .temp_return_irq_enable, .temp_report_enable, .port_disabled);

// File: tb/i2c_host_model.sv
/* Two-wire host controller model, 64 ns bit period.
 * Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ns
module i2c_host_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		#16 sda_low = ~b;
		#16 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
	endtask : bit_io
	task automatic start();
		#16 sda_low = 1'b0;
		#16 scl = 1'b1;
		#16 sda_low = 1'b1;
		#16 scl = 1'b0;
	endtask : start
	task automatic stop();
		#16 sda_low = 1'b1;
		#16 scl = 1'b1;
		#16 sda_low = 1'b0;
	endtask : stop
	// MSB first; ninth bit released, so a read ends in no-acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : xfer
endmodule : i2c_host_model

// File: tb/temp_i2c_port_tb_top.sv
/* Self-checking bench for temp_i2c_port.
 * Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ns
module temp_i2c_port_tb_top;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic temp_in_range = 1'b1;
	logic scl_in, sda_in, host_low, sda_out, sda_oe, temp_event_flag, temp_in_range_level;
	logic temp_exit_irq_enable, temp_return_irq_enable, temp_report_enable, port_disabled;
	logic [7:0] q, e;
	logic [2:0] a;
	logic k;
	logic [7:0] tcfg [4] = '{8'h05, 8'h06, 8'h03, 8'h07};
	logic [15:0] seq [6] = '{16'h0BEE, 16'h0207, 16'h0301, 16'h0BEF, 16'h0207, 16'h0301};
	int error_cnt = 0;
	int checked = 0;
	assign sda_in = !(host_low || (sda_oe && !sda_out));
	always #10 ref_clk = ~ref_clk;
	temp_i2c_port temp_i2c_port_inst (.ref_clk, .resetn, .temp_in_range, .scl_in, .sda_in,
		.sda_out, .sda_oe, .temp_event_flag, .temp_in_range_level, .temp_exit_irq_enable,
		.temp_return_irq_enable, .temp_report_enable, .port_disabled);
	// Sole target on this bus
	i2c_host_model i2c_host_model_inst (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : wait_clk
	task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic [2:0] ak);
		logic [7:0] x;
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer({temp_i2c_pkg::DEV_ADDR, 1'b0}, x, ak[2]);
		i2c_host_model_inst.xfer(r, x, ak[1]);
		i2c_host_model_inst.xfer(d, x, ak[0]);
		i2c_host_model_inst.stop();
		wait_clk(10);
	endtask : wr
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic [7:0] x;
		logic n;
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer({temp_i2c_pkg::DEV_ADDR, 1'b0}, x, n);
		i2c_host_model_inst.xfer(r, x, n);
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer({temp_i2c_pkg::DEV_ADDR, 1'b1}, x, n);
		i2c_host_model_inst.xfer(8'hFF, d, n);
		i2c_host_model_inst.stop();
		wait_clk(10);
	endtask : rd
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		error_cnt++;
		end_sim();
	end
	initial begin
		// Link flops need clocks and a data fall while reset is held
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer(8'hFF, q, k);
		i2c_host_model_inst.stop();
		wait_clk(1);
		resetn = 1'b1;
		// Link reset synchroniser needs SCL rises after release too
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer(8'hFF, q, k);
		i2c_host_model_inst.stop();
		wait_clk(60);
		rd(temp_i2c_pkg::TEMP_REG_ADDR, q);
		chk(q, 8'h10);
		$display("Test reset done");
		for (int i = 0; i < 4; i++) begin
			e = tcfg[i] | {3'h0, i[0], tcfg[i][2], 3'h0};
			wr(temp_i2c_pkg::TEMP_REG_ADDR, tcfg[i], a);
			chk({5'h0, a}, 8'h07);
			chk({5'h0, temp_report_enable, temp_return_irq_enable, temp_exit_irq_enable},
				tcfg[i]);
			temp_in_range = i[0];
			wait_clk(8);
			chk({6'h0, temp_in_range_level, temp_event_flag}, {6'h0, e[4:3]});
			rd(temp_i2c_pkg::TEMP_REG_ADDR, q);
			chk(q, e);
			rd(temp_i2c_pkg::TEMP_REG_ADDR, q);
			chk(q, e & 8'hF7);
			$display("Test event %0d done", i);
		end
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer({temp_i2c_pkg::DEV_ADDR ^ 7'h01, 1'b0}, q, k);
		i2c_host_model_inst.stop();
		chk({7'h0, k}, 8'h00);
		wr(8'h20, 8'h11, a);
		chk({5'h0, a}, 8'h07);
		rd(8'h20, q);
		chk(q, 8'h00);
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer({temp_i2c_pkg::DEV_ADDR, 1'b0}, q, k);
		i2c_host_model_inst.xfer(8'h20, q, k);
		i2c_host_model_inst.xfer(8'h11, q, k);
		i2c_host_model_inst.xfer(8'h22, q, k);
		i2c_host_model_inst.stop();
		chk({7'h0, k}, 8'h00);
		$display("Test refusals done");
		for (int i = 0; i < 6; i++) begin
			chk({7'h0, port_disabled}, 8'h00);
			wr(seq[i][15:8], seq[i][7:0], a);
		end
		chk({7'h0, port_disabled}, 8'h01);
		wr(temp_i2c_pkg::TEMP_REG_ADDR, 8'h00, a);
		chk({5'h0, a}, 8'h00);
		chk({5'h0, temp_report_enable, temp_return_irq_enable, temp_exit_irq_enable},
			8'h07);
		$display("Test disable done");
		end_sim();
	end
endmodule : temp_i2c_port_tb_top
